// ==== design/can_fs_pkg.sv ====
// Shared types and constants of the CAN transceiver fail-safe supervisor.
package can_fs_pkg;

   // ---------------------------------------------------------------
   // Timebase
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;

   // ---------------------------------------------------------------
   // Times in their own unit and the cycle counts derived from them
   // ---------------------------------------------------------------
   // Undervoltage filter time is a least time, so it rounds up.
   localparam int UV_FILTER_NS  = 6000;
   localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Recovery time is a longest time, so it rounds down.
   localparam int UV_RECOV_NS   = 7000;
   localparam int UV_RECOV_CYC  = UV_RECOV_NS / CLK_PERIOD_NS;
   // Power-up delay is a least time, so it rounds up.
   localparam int PON_NS        = 40000;
   localparam int PON_CYC       = (PON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Mode-change window is a longest time, so it rounds down.
   localparam int MODE_NS       = 8000;
   localparam int MODE_CYC      = MODE_NS / CLK_PERIOD_NS;
   // Dominant time-out default, a least time, rounds up.
   localparam int TXD_TIMEOUT_NS  = 2300000;
   localparam int TXD_TIMEOUT_DEF = (TXD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Counter widths and reset values
   // ---------------------------------------------------------------
   localparam int MODE_CNT_W = 12;
   localparam int TXD_CNT_W  = 20;
   localparam logic TXD_RESET_LEVEL = 1'b1;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_PWR_DOWN   = 3'h0,
      ST_STANDBY    = 3'h1,
      ST_TO_NORMAL  = 3'h2,
      ST_NORMAL     = 3'h3,
      ST_TO_STANDBY = 3'h4
   } mode_state_t;

   typedef struct packed {
      logic tx_supply_uv;
      logic logic_supply_uv;
      logic overtemp;
   } ana_flags_t;

   typedef struct packed {
      logic in_powerdown;
      logic in_standby;
      logic in_normal;
      logic mode_changing;
      logic txd_timeout;
      logic uv_block;
      logic ot_block;
   } fs_status_t;

endpackage

// ==== design/flag_sync.sv ====
// Two-stage synchroniser for a group of asynchronous comparator flags.
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // Flags
   input  wire logic [WIDTH-1:0] flag_async,
   output logic      [WIDTH-1:0] flag_sync
);

   // ---------------------------------------------------------------
   // One chain per flag; the first stage feeds only the second.
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               meta         <= 1'b0;
               flag_sync[i] <= 1'b0;
            end else begin
               meta         <= flag_async[i];
               flag_sync[i] <= meta;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ==== design/persist_filter.sv ====
// Level filter: the output follows the input only after it has persisted.
`timescale 1ns/1ps
`default_nettype none
module persist_filter #(
   parameter int SET_CYC = 600,
   parameter int CLR_CYC = 700
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Level
   input  wire logic level_in,
   output logic      level_out
);

   localparam int CNT_MAX = (SET_CYC > CLR_CYC) ? SET_CYC : CLR_CYC;
   localparam int CNT_W   = $clog2(CNT_MAX + 1);

   logic [CNT_W-1:0] run;

   // ---------------------------------------------------------------
   // Count cycles of disagreement; any agreeing cycle restarts the count.
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         run       <= '0;
         level_out <= 1'b0;
      end else if (level_in == level_out) begin
         run <= '0;
      end else if ((level_in && run == CNT_W'(SET_CYC - 1)) ||
                   (!level_in && run == CNT_W'(CLR_CYC - 1))) begin
         run       <= '0;
         level_out <= level_in;
      end else begin
         run <= run + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ==== design/can_transceiver_failsafe_ctrl.sv ====
// Fail-safe supervisor gating the CAN transmitter and receive output.
//
// Behaviour
// - Open inputs read high, so after power-up the device settles in stand-by.
// - Transmitter supply undervoltage in normal mode blocks all dominant driving.
// - Transmitter supply undervoltage in normal mode switches bus biasing to ground.
// - Transmit input low beyond the dominant time-out latches a transmitter-off state.
// - During a time-out the receiver stays on and the receive output follows the bus.
// - Only a low-to-high transmit input edge or leaving normal mode clears the latched time-out.
// - Each requested mode change completes within the mode-change window.
// - Receive output held high while changing from stand-by to normal.
// - After the mode change the receive output follows the bus again.
// - Overtemperature is honoured in normal mode only.
// - Overtemperature disables the transmitter but stays in normal mode.
// - Transmitter re-enables by itself once overtemperature clears.
// - Transmit input low at normal entry keeps transmit off until seen high.
// - Logic supply undervoltage forces power-down regardless of other inputs.
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_failsafe_ctrl
   import can_fs_pkg::*;
#(
   parameter int TXD_TIMEOUT_CYC = TXD_TIMEOUT_DEF
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Host controller pins
   input  wire logic txd_in,
   input  wire logic mode_select,
   output logic      rxd_out,
   // Analogue comparators and receiver
   input  wire ana_flags_t ana_flags,
   input  wire logic       bus_rx_dominant,
   // Analogue driver controls
   output logic      tx_drive_dominant,
   output logic      tx_enable,
   output logic      rx_enable,
   output logic      bias_active,
   output logic      bias_gnd,
   // Status
   output fs_status_t status
);

   // ---------------------------------------------------------------
   // Comparator flag synchronisation and undervoltage filtering
   // ---------------------------------------------------------------
   ana_flags_t ana_sync;
   logic       uv_filt;

   // The flags come from analogue comparators on no clock at all.
   flag_sync #(
      .WIDTH      ($bits(ana_flags_t))
   ) u_sync (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .flag_async (ana_flags),
      .flag_sync  (ana_sync)
   );

   // Short dips are ignored; blocking also outlasts short recoveries.
   persist_filter #(
      .SET_CYC   (UV_FILTER_CYC),
      .CLR_CYC   (UV_RECOV_CYC)
   ) u_uv_filter (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .level_in  (ana_sync.tx_supply_uv),
      .level_out (uv_filt)
   );

   // ---------------------------------------------------------------
   // Mode sequencing
   // ---------------------------------------------------------------
   mode_state_t           state;
   logic [MODE_CNT_W-1:0] mode_cnt;

   // Logic supply loss overrides everything, so it is tested first.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state    <= ST_PWR_DOWN;
         mode_cnt <= '0;
      end else if (ana_sync.logic_supply_uv) begin
         state    <= ST_PWR_DOWN;
         mode_cnt <= '0;
      end else begin
         unique case (state)
            ST_PWR_DOWN: begin
               // Pulled-up inputs make stand-by the natural landing state.
               if (mode_cnt == MODE_CNT_W'(PON_CYC - 1)) begin
                  state    <= ST_STANDBY;
                  mode_cnt <= '0;
               end else begin
                  mode_cnt <= mode_cnt + 1'b1;
               end
            end
            ST_STANDBY: begin
               // Normal needs a healthy transmitter supply.
               if (!mode_select && !uv_filt) begin
                  state    <= ST_TO_NORMAL;
                  mode_cnt <= '0;
               end
            end
            ST_TO_NORMAL: begin
               if (mode_cnt == MODE_CNT_W'(MODE_CYC - 1)) begin
                  state    <= ST_NORMAL;
                  mode_cnt <= '0;
               end else begin
                  mode_cnt <= mode_cnt + 1'b1;
               end
            end
            ST_NORMAL: begin
               if (mode_select) begin
                  state    <= ST_TO_STANDBY;
                  mode_cnt <= '0;
               end
            end
            ST_TO_STANDBY: begin
               if (mode_cnt == MODE_CNT_W'(MODE_CYC - 1)) begin
                  state    <= ST_STANDBY;
                  mode_cnt <= '0;
               end else begin
                  mode_cnt <= mode_cnt + 1'b1;
               end
            end
            default: begin
               state    <= ST_PWR_DOWN;
               mode_cnt <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Transmit arming at normal entry
   // ---------------------------------------------------------------
   logic tx_armed;

   // A dominant level held through the mode change must not reach the bus.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_armed <= 1'b0;
      end else if (state != ST_TO_NORMAL && state != ST_NORMAL) begin
         tx_armed <= 1'b0;
      end else if (txd_in) begin
         tx_armed <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Dominant time-out
   // ---------------------------------------------------------------
   logic                 txd_prev;
   logic [TXD_CNT_W-1:0] low_cnt;
   logic                 txd_timeout;
   logic                 timeout_hit;

   assign timeout_hit = !txd_in && (low_cnt == TXD_CNT_W'(TXD_TIMEOUT_CYC - 1));

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         txd_prev <= TXD_RESET_LEVEL;
      end else begin
         txd_prev <= txd_in;
      end
   end

   // Counts consecutive low cycles in normal mode and stops at the limit.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         low_cnt <= '0;
      end else if (state != ST_NORMAL || txd_in) begin
         low_cnt <= '0;
      end else if (!timeout_hit) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // Leaving normal mode clears the latch; in normal it only lets go on a rising edge, and the set is tested before that.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         txd_timeout <= 1'b0;
      end else if (state != ST_NORMAL) begin
         txd_timeout <= 1'b0;
      end else if (timeout_hit) begin
         txd_timeout <= 1'b1;
      end else if (!txd_prev && txd_in) begin
         txd_timeout <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Gating terms
   // ---------------------------------------------------------------
   logic in_normal;
   logic uv_block;
   logic ot_block;
   logic tx_ok;

   assign in_normal = (state == ST_NORMAL);
   assign uv_block  = in_normal && uv_filt;
   assign ot_block  = in_normal && ana_sync.overtemp;
   assign tx_ok     = in_normal && tx_armed && !txd_timeout && !uv_block && !ot_block;

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   // Every output is a flop, so the analogue side never sees a glitch.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_drive_dominant <= 1'b0;
         tx_enable         <= 1'b0;
         rx_enable         <= 1'b0;
         bias_active       <= 1'b0;
         bias_gnd          <= 1'b0;
      end else begin
         tx_drive_dominant <= tx_ok && !txd_in;
         tx_enable         <= tx_ok;
         // The receiver ignores the time-out and stays on.
         rx_enable         <= in_normal || state == ST_TO_STANDBY;
         bias_active       <= in_normal && !uv_filt;
         bias_gnd          <= uv_block;
      end
   end

   // Stand-by shows recessive here; wake-up signalling lives elsewhere.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rxd_out <= 1'b1;
      end else if (in_normal || state == ST_TO_STANDBY) begin
         rxd_out <= !bus_rx_dominant;
      end else begin
         rxd_out <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status <= '{in_powerdown: 1'b1, default: 1'b0};
      end else begin
         status.in_powerdown  <= (state == ST_PWR_DOWN);
         status.in_standby    <= (state == ST_STANDBY);
         status.in_normal     <= in_normal;
         status.mode_changing <= (state == ST_TO_NORMAL) || (state == ST_TO_STANDBY);
         status.txd_timeout   <= txd_timeout;
         status.uv_block      <= uv_block;
         status.ot_block      <= ot_block;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   localparam int MODE_BOUND = MODE_CYC + 1;

   logic [15:0]          uv_run;
   logic [15:0]          ok_run;
   logic [15:0]          pon_run;
   logic [TXD_CNT_W:0]   low_run;

   // Helper run-length counters read only by the checks below.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         uv_run  <= '0;
         ok_run  <= '0;
         pon_run <= '0;
         low_run <= '0;
      end else begin
         uv_run  <= ana_sync.tx_supply_uv ? uv_run + 16'h0001 : 16'h0000;
         ok_run  <= ana_sync.tx_supply_uv ? 16'h0000 : ok_run + 16'h0001;
         pon_run <= ana_sync.logic_supply_uv ? 16'h0000 :
                    ((&pon_run) ? pon_run : pon_run + 16'h0001);
         low_run <= (in_normal && !txd_in) ? low_run + 1'b1 : '0;
      end
   end

   sequence s_change_start;
      $rose(status.mode_changing);
   endsequence

   sequence s_change_done;
      !status.mode_changing;
   endsequence

   a_uv_blocks_tx: assert property (status.uv_block |-> !tx_drive_dominant)
      else $error("Dominant driven during supply undervoltage.");
   a_uv_bias_gnd: assert property (status.uv_block |-> bias_gnd && !bias_active)
      else $error("Bias not grounded during supply undervoltage.");
   a_uv_filter_min: assert property ($rose(uv_filt) |-> $past(uv_run) >= UV_FILTER_CYC - 1)
      else $error("Undervoltage recognised before filter time.");
   a_uv_recovery_max: assert property (uv_filt |-> ok_run <= UV_RECOV_CYC)
      else $error("Undervoltage blocking outlived recovery time.");
   a_timeout_latch: assert property ((in_normal && low_run >= TXD_TIMEOUT_CYC + 2)
                                     |-> status.txd_timeout)
      else $error("Time-out not latched after long low input.");
   a_rx_follows_bus: assert property (in_normal |=> rxd_out == !$past(bus_rx_dominant))
      else $error("Receive output does not follow bus in normal mode.");
   a_timeout_release: assert property ($fell(txd_timeout) && $past(in_normal) && in_normal
                                       |-> $past(txd_in) && !$past(txd_prev))
      else $error("Time-out cleared without a rising transmit edge.");
   a_mode_window: assert property (s_change_start |-> ##[1:MODE_BOUND] s_change_done)
      else $error("Mode change outran its window.");
   a_rx_high_change: assert property (state == ST_TO_NORMAL |=> rxd_out)
      else $error("Receive output not held high during mode change.");
   a_ot_ignored: assert property (!in_normal |=> !status.ot_block && !tx_enable)
      else $error("Overtemperature honoured outside normal mode.");
   a_ot_stays_normal: assert property ((in_normal && ana_sync.overtemp && !mode_select
                                        && !ana_sync.logic_supply_uv)
                                       |=> !tx_enable && state == ST_NORMAL)
      else $error("Overtemperature handling left normal mode or kept transmitter on.");
   // Built from the raw gate inputs, so a wrong polarity in the gating terms shows up here.
   a_ot_reenable: assert property ((in_normal && tx_armed && !txd_timeout && !uv_filt
                                    && !ana_sync.overtemp && !txd_in) |=> tx_drive_dominant)
      else $error("Transmitter not re-enabled with all faults clear.");
   a_pon_delay: assert property ((state == ST_PWR_DOWN) ##1 (state != ST_PWR_DOWN)
                                 |-> $past(pon_run) >= PON_CYC - 1)
      else $error("Power-down left before power-up delay.");
   a_arm_gate: assert property (in_normal && !tx_armed |=> !tx_drive_dominant)
      else $error("Dominant driven before transmit input seen high.");
   a_uv_powerdown: assert property (ana_sync.logic_supply_uv |-> ##2 status.in_powerdown)
      else $error("Logic supply loss did not force power-down.");

endmodule
`default_nettype wire

// ==== dv/can_host_model.sv ====
// Host controller pins with the device's input pull-ups.
`timescale 1ns/1ps
`default_nettype none
module can_host_model (
   // Host intent
   input  wire logic drive_en,
   input  wire logic want_txd,
   input  wire logic want_mode,
   // Device pins
   output logic      txd_in,
   output logic      mode_select
);
   // A released pin floats up to the pull-up, so open means high.
   // The host ends a time-out by returning txd high or by leaving normal mode.
   assign txd_in      = drive_en ? want_txd : 1'b1;
   assign mode_select = drive_en ? want_mode : 1'b1;
endmodule
`default_nettype wire

// ==== dv/test_can_transceiver_failsafe_ctrl.sv ====
// Self-checking bench for the fail-safe supervisor.
`timescale 1ns/1ps
`default_nettype none
module test_can_transceiver_failsafe_ctrl;
   import can_fs_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int TO_CYC = 50;
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       drive_en = 1'b0;
   logic       want_txd = 1'b1;
   logic       want_mode = 1'b1;
   logic       bus_force = 1'b0;
   ana_flags_t ana = '0;
   wire logic  txd_in, mode_select, rxd_out, tx_drv, tx_en, rx_en, b_act, b_gnd;
   wire logic  bus_rx_dominant;
   fs_status_t status;
   int         fails = 0;
   int         checked = 0;
   int         cycles = 0;
   // The bus reads dominant when we drive it or another node forces it.
   assign bus_rx_dominant = tx_drv | bus_force;
   can_host_model host (.drive_en(drive_en), .want_txd(want_txd), .want_mode(want_mode),
      .txd_in(txd_in), .mode_select(mode_select));
   can_transceiver_failsafe_ctrl #(.TXD_TIMEOUT_CYC(TO_CYC)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .txd_in(txd_in), .mode_select(mode_select),
      .rxd_out(rxd_out), .ana_flags(ana), .bus_rx_dominant(bus_rx_dominant),
      .tx_drive_dominant(tx_drv), .tx_enable(tx_en), .rx_enable(rx_en),
      .bias_active(b_act), .bias_gnd(b_gnd), .status(status));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // The whole run needs about 12000 cycles, so 40000 means a hang.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic check(input logic seen, input logic exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Counts: %0d checked, %0d failed", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_powerup();
      wait_cyc(2);
      check(status.in_powerdown, 1'b1);
      check(rxd_out, 1'b1);
      wait_cyc(3980);
      check(status.in_powerdown, 1'b1);
      wait_cyc(40);
      check(status.in_standby, 1'b1);
      $display("power-up done");
   endtask
   // Entry with txd low, bus busy: rxd held high, transmit stays off.
   task automatic t_to_normal();
      drive_en = 1'b1;
      want_txd = 1'b0;
      want_mode = 1'b0;
      bus_force = 1'b1;
      wait_cyc(5);
      check(status.mode_changing, 1'b1);
      check(rxd_out, 1'b1);
      wait_cyc(810);
      check(status.in_normal, 1'b1);
      check(rxd_out, 1'b0);
      check(tx_drv, 1'b0);
      check(tx_en, 1'b0);
      bus_force = 1'b0;
      want_txd = 1'b1;
      wait_cyc(3);
      check(tx_en, 1'b1);
      check(rxd_out, 1'b1);
      $display("mode change done");
   endtask
   task automatic t_timeout();
      want_txd = 1'b0;
      wait_cyc(TO_CYC - 10);
      check(tx_drv, 1'b1);
      check(rxd_out, 1'b0);
      wait_cyc(20);
      check(status.txd_timeout, 1'b1);
      check(tx_drv, 1'b0);
      bus_force = 1'b1;
      wait_cyc(20);
      check(status.txd_timeout, 1'b1);
      check(rx_en, 1'b1);
      check(rxd_out, 1'b0);
      bus_force = 1'b0;
      want_txd = 1'b1;
      wait_cyc(3);
      check(status.txd_timeout, 1'b0);
      check(tx_en, 1'b1);
      $display("time-out done");
   endtask
   // Undervoltage blocks only after the filter count; recovery only after the clear count.
   task automatic t_uv();
      ana.tx_supply_uv = 1'b1;
      wait_cyc(400);
      check(status.uv_block, 1'b0);
      wait_cyc(230);
      // A short dominant request, well inside the time-out, so only the block can stop it.
      want_txd = 1'b0;
      wait_cyc(5);
      check(status.uv_block, 1'b1);
      check(tx_drv, 1'b0);
      check(b_gnd, 1'b1);
      check(b_act, 1'b0);
      want_txd = 1'b1;
      ana.tx_supply_uv = 1'b0;
      wait_cyc(500);
      check(status.uv_block, 1'b1);
      wait_cyc(250);
      check(status.uv_block, 1'b0);
      check(b_gnd, 1'b0);
      check(tx_en, 1'b1);
      $display("undervoltage done");
   endtask
   // A dominant request stands through the hot spell; it must reach the bus only after it.
   task automatic t_ot();
      ana.overtemp = 1'b1;
      want_txd = 1'b0;
      wait_cyc(6);
      check(status.ot_block, 1'b1);
      check(tx_en, 1'b0);
      check(tx_drv, 1'b0);
      check(status.in_normal, 1'b1);
      ana.overtemp = 1'b0;
      wait_cyc(6);
      check(tx_en, 1'b1);
      check(tx_drv, 1'b1);
      want_txd = 1'b1;
      $display("overtemperature done");
   endtask
   // Logic supply loss from normal; then open pins settle in stand-by.
   task automatic t_lsuv();
      ana.logic_supply_uv = 1'b1;
      wait_cyc(6);
      check(status.in_powerdown, 1'b1);
      check(tx_en, 1'b0);
      check(rx_en, 1'b0);
      drive_en = 1'b0;
      ana.logic_supply_uv = 1'b0;
      wait_cyc(4030);
      check(status.in_standby, 1'b1);
      ana.overtemp = 1'b1;
      bus_force = 1'b1;
      wait_cyc(10);
      check(status.ot_block, 1'b0);
      check(rxd_out, 1'b1);
      $display("power-down done");
   endtask
   // Round trip to normal and back; the receiver stays on until stand-by is reached.
   task automatic t_to_standby();
      ana.overtemp = 1'b0;
      bus_force = 1'b0;
      drive_en = 1'b1;
      want_txd = 1'b1;
      want_mode = 1'b0;
      wait_cyc(810);
      check(status.in_normal, 1'b1);
      want_mode = 1'b1;
      bus_force = 1'b1;
      wait_cyc(5);
      check(status.mode_changing, 1'b1);
      check(rx_en, 1'b1);
      check(rxd_out, 1'b0);
      wait_cyc(810);
      check(status.in_standby, 1'b1);
      check(rx_en, 1'b0);
      check(rxd_out, 1'b1);
      $display("stand-by return done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      wait_cyc(8);
      sys_rst = 1'b0;
      t_powerup();
      t_to_normal();
      t_timeout();
      t_uv();
      t_ot();
      t_lsuv();
      t_to_standby();
      finish_test();
   end
endmodule
`default_nettype wire
